/* core/aoc_alarm_conditioner.sv */
// Purpose: Delay, latch and polarity stage between alarm comparison and auxiliary outputs.
// Assumes: Inputs synchronous to clk; single-cycle register strobes.
// Notes:   Register read data appear one cycle after the read strobe.
`timescale 1ns/1ps
module aoc_alarm_conditioner #(
    parameter int TICK_CYCLES = aoc_pkg::TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic [3:0]  rawAlarm,
    input  wire logic        functionKey,
    input  wire logic [5:0]  eventIn,
    input  wire logic        setupLevel,
    output logic      [3:0]  auxOut,
    output logic      [3:0]  alarmState,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [3:0][9:0]    onDly;
        logic [3:0][9:0]    offDly;
        logic [3:0][3:0]    chType;
        logic [3:0]         latchEn;
        logic [3:0]         openInAlarm;
        logic [3:0]         assigned;
        logic               keyLatCancel;
        logic [5:0]         evtLatCancel;
        logic [31:0]        tickCnt;
        logic               tick;
        aoc_pkg::aoc_ch_t [3:0] ch;
        logic [3:0]         funcOut;
        logic [3:0]         aux;
        logic               keyLast;
        logic [5:0]         evtLast;
        logic [31:0]        rdata;
        logic [3:0]         irqStat;
        logic [3:0]         irqMask;
        logic               irqOut;
    } aoc_state_t;

    aoc_state_t stReg;
    aoc_state_t stNext;

    logic       cancelHit;
    logic [3:0] latchOk;
    logic [3:0] delayOk;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        stNext = stReg;
        stNext.tick = 1'b0;
        // A one-second tick keeps 10-bit counters instead of 38-bit cycle counters per channel.
        if (stReg.tickCnt >= 32'(TICK_CYCLES - 1)) begin
            stNext.tickCnt = 32'h0000_0000;
            stNext.tick    = 1'b1;
        end else begin
            stNext.tickCnt = stReg.tickCnt + 32'h0000_0001;
        end
        stNext.keyLast = functionKey;
        stNext.evtLast = eventIn;
        cancelHit = (stReg.keyLatCancel && functionKey && !stReg.keyLast)
                  || |(stReg.evtLatCancel & eventIn & ~stReg.evtLast);
        for (int i = 0; i < aoc_pkg::NUM_CH; i++) begin
            latchOk[i] = (i == 0) ? (stReg.chType[i] != aoc_pkg::TYPE_NONE)
                       : (stReg.chType[i] != aoc_pkg::TYPE_NONE
                          && stReg.chType[i] != aoc_pkg::TYPE_LOOP);
            delayOk[i] = stReg.assigned[i]
                       && stReg.chType[i] != aoc_pkg::TYPE_NONE
                       && stReg.chType[i] != aoc_pkg::TYPE_LOOP
                       && stReg.chType[i] != aoc_pkg::TYPE_NODELAY;
            stNext.ch[i].rawLast = rawAlarm[i];
            if (rawAlarm[i] != stReg.ch[i].rawLast) begin
                stNext.ch[i].cnt = 10'h000;
            end else if (stReg.tick && stReg.ch[i].cnt <= aoc_pkg::DELAY_MAX) begin
                stNext.ch[i].cnt = stReg.ch[i].cnt + 10'h001;
            end
            case (stReg.ch[i].st)
                aoc_pkg::AOC_IDLE: begin
                    if (rawAlarm[i]) begin
                        if (!delayOk[i] || stReg.onDly[i] == 10'h000) begin
                            stNext.ch[i].st = aoc_pkg::AOC_ACTIVE;
                        end else begin
                            stNext.ch[i].st  = aoc_pkg::AOC_ONWAIT;
                            stNext.ch[i].cnt = 10'h000;
                        end
                    end
                end
                aoc_pkg::AOC_ONWAIT: begin
                    if (!rawAlarm[i]) begin
                        stNext.ch[i].st = aoc_pkg::AOC_IDLE;
                    // The first tick may come at once, so one tick past the setting is needed.
                    end else if (stReg.ch[i].cnt > stReg.onDly[i]) begin
                        stNext.ch[i].st = aoc_pkg::AOC_ACTIVE;
                    end
                end
                aoc_pkg::AOC_ACTIVE: begin
                    if (!rawAlarm[i]) begin
                        if (!delayOk[i] || stReg.offDly[i] == 10'h000) begin
                            stNext.ch[i].st = aoc_pkg::AOC_IDLE;
                        end else begin
                            stNext.ch[i].st  = aoc_pkg::AOC_OFFWAIT;
                            stNext.ch[i].cnt = 10'h000;
                        end
                    end
                end
                aoc_pkg::AOC_OFFWAIT: begin
                    if (rawAlarm[i]) begin
                        stNext.ch[i].st = aoc_pkg::AOC_ACTIVE;
                    end else if (stReg.ch[i].cnt > stReg.offDly[i]) begin
                        stNext.ch[i].st = aoc_pkg::AOC_IDLE;
                    end
                end
                default: begin
                    stNext.ch[i].st = aoc_pkg::AOC_IDLE;
                end
            endcase
            // A cancel arriving with a fresh alarm wins; the alarm relatches next cycle.
            if (cancelHit || !stReg.latchEn[i] || !latchOk[i]) begin
                stNext.ch[i].latched = 1'b0;
            end else if (stReg.ch[i].st == aoc_pkg::AOC_ACTIVE) begin
                stNext.ch[i].latched = 1'b1;
            end
            stNext.funcOut[i] = !setupLevel
                && (stNext.ch[i].st == aoc_pkg::AOC_ACTIVE
                    || stNext.ch[i].st == aoc_pkg::AOC_OFFWAIT
                    || stNext.ch[i].latched);
            if (setupLevel) begin
                stNext.ch[i].st = aoc_pkg::AOC_IDLE;
            end
        end
        stNext.irqStat = stReg.irqStat;
        if (regRd && regAddr == aoc_pkg::REG_IRQ_STAT) begin
            stNext.irqStat = 4'h0;
        end
        // Set beats clear so an edge landing on the read is not lost.
        stNext.irqStat = stNext.irqStat | (stNext.funcOut & ~stReg.funcOut);
        stNext.irqOut  = |(stNext.irqStat & stNext.irqMask);
        if (regWr) begin
            case (regAddr)
                4'h0, 4'h1, 4'h2, 4'h3: begin
                    stNext.onDly[regAddr[1:0]] = (regWdata[9:0] > aoc_pkg::DELAY_MAX)
                        ? aoc_pkg::DELAY_MAX : regWdata[9:0];
                end
                4'h4, 4'h5, 4'h6, 4'h7: begin
                    stNext.offDly[regAddr[1:0]] = (regWdata[9:0] > aoc_pkg::DELAY_MAX)
                        ? aoc_pkg::DELAY_MAX : regWdata[9:0];
                end
                aoc_pkg::REG_TYPES: begin
                    stNext.chType = regWdata[15:0];
                end
                aoc_pkg::REG_CONFIG: begin
                    stNext.latchEn      = regWdata[aoc_pkg::CFG_LATCH +: 4];
                    stNext.openInAlarm  = regWdata[aoc_pkg::CFG_OPEN +: 4];
                    stNext.assigned     = regWdata[aoc_pkg::CFG_ASSIGN +: 4];
                    stNext.keyLatCancel = regWdata[aoc_pkg::CFG_KEYLAT];
                    stNext.evtLatCancel = regWdata[aoc_pkg::CFG_EVTLAT +: 6];
                end
                aoc_pkg::REG_IRQ_MASK: begin
                    stNext.irqMask = regWdata[3:0];
                end
                default: begin
                end
            endcase
        end
        stNext.aux   = stNext.funcOut ^ stNext.openInAlarm;
        stNext.rdata = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                4'h0, 4'h1, 4'h2, 4'h3: stNext.rdata = {22'h0, stReg.onDly[regAddr[1:0]]};
                4'h4, 4'h5, 4'h6, 4'h7: stNext.rdata = {22'h0, stReg.offDly[regAddr[1:0]]};
                aoc_pkg::REG_TYPES:    stNext.rdata = {16'h0, stReg.chType};
                aoc_pkg::REG_CONFIG:   stNext.rdata = {10'h0, stReg.evtLatCancel, 3'h0,
                    stReg.keyLatCancel, stReg.assigned, stReg.openInAlarm, stReg.latchEn};
                aoc_pkg::REG_STATUS:   stNext.rdata = {24'h0, stReg.aux, stReg.funcOut};
                aoc_pkg::REG_IRQ_STAT: stNext.rdata = {28'h0, stReg.irqStat};
                aoc_pkg::REG_IRQ_MASK: stNext.rdata = {28'h0, stReg.irqMask};
                aoc_pkg::REG_STATE:    stNext.rdata = {24'h0,
                    stReg.ch[3].st, stReg.ch[2].st, stReg.ch[1].st, stReg.ch[0].st};
                default:               stNext.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stReg <= '0;
        end else if (clkEn) begin
            stReg <= stNext;
        end
    end

    assign regRdata   = stReg.rdata;
    assign auxOut     = stReg.aux;
    assign alarmState = stReg.funcOut;
    assign irq        = stReg.irqOut;

    ////////////////////////////////////////////////////////////////////////////
    AST_LEVEL_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && setupLevel) |=> (alarmState == 4'h0))
        else $error("Alarm state not forced off in setup level.");
    AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
        (auxOut == (alarmState ^ stReg.openInAlarm)))
        else $error("Aux output polarity mismatch.");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.ch[0].latched && !cancelHit && !setupLevel
         && stReg.latchEn[0] && latchOk[0]) |=> alarmState[0])
        else $error("Latched alarm dropped without cancel.");
    AST_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && cancelHit) |=> (!stReg.ch[0].latched && !stReg.ch[1].latched
                                  && !stReg.ch[2].latched && !stReg.ch[3].latched))
        else $error("Cancel did not clear latch.");
    AST_ON_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !setupLevel && stReg.onDly[0] == 10'h000
         && stReg.ch[0].st == aoc_pkg::AOC_IDLE && rawAlarm[0]) |=> alarmState[0])
        else $error("Zero ON delay did not fire at once.");
    AST_ON_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
        (stReg.ch[0].st == aoc_pkg::AOC_ONWAIT && !stReg.ch[0].latched)
        |-> !alarmState[0])
        else $error("Output on during ON delay.");
    AST_OFF_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.offDly[2] == 10'h000 && !stReg.latchEn[2]
         && stReg.ch[2].st == aoc_pkg::AOC_ACTIVE && !rawAlarm[2]) |=> !alarmState[2])
        else $error("Zero OFF delay did not clear at once.");
    AST_NO_LATCH_TYPE: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.chType[1] == aoc_pkg::TYPE_LOOP) |=> !stReg.ch[1].latched)
        else $error("Latch set for excluded type.");
    AST_TICK: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.tick) |=> !stReg.tick)
        else $error("Tick longer than one cycle.");

    ////////////////////////////////////////////////////////////////////////////
    AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
        !clkEn |=> $stable(stReg))
        else $error("State moved while clock enable was low.");
    AST_KEY_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.keyLatCancel && functionKey && !stReg.keyLast)
        |=> !stReg.ch[0].latched)
        else $error("Key cancel left channel 0 latched.");
    AST_EVT_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.evtLatCancel[5] && eventIn[5] && !stReg.evtLast[5])
        |=> !stReg.ch[0].latched)
        else $error("Event cancel left channel 0 latched.");
    AST_LATCH_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
        (stReg.ch[0].latched && alarmState[0]) |-> (auxOut[0] != stReg.openInAlarm[0]))
        else $error("Latched output left its alarm position.");
    AST_LATCH_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !stReg.latchEn[0]) |=> !stReg.ch[0].latched)
        else $error("Latch held while disabled.");
    AST_LATCH_TYPE0: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.chType[0] == aoc_pkg::TYPE_NONE) |=> !stReg.ch[0].latched)
        else $error("Latch set for type zero.");
    AST_LATCH_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.latchEn[0] && latchOk[0] && !cancelHit
         && stReg.ch[0].st == aoc_pkg::AOC_ACTIVE) |=> stReg.ch[0].latched)
        else $error("Active alarm was not latched.");
    AST_ON_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !stReg.latchEn[0] && rawAlarm[0]
         && stReg.ch[0].st == aoc_pkg::AOC_ONWAIT
         && stReg.ch[0].cnt <= stReg.onDly[0]) |=> !alarmState[0])
        else $error("Output on before the ON delay elapsed.");
    AST_ON_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !setupLevel && rawAlarm[0] && stReg.ch[0].st == aoc_pkg::AOC_ONWAIT
         && stReg.ch[0].cnt > stReg.onDly[0]) |=> alarmState[0])
        else $error("Output not on after the ON delay.");
    AST_OFF_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !setupLevel && !rawAlarm[0] && stReg.ch[0].st == aoc_pkg::AOC_OFFWAIT
         && stReg.ch[0].cnt <= stReg.offDly[0]) |=> alarmState[0])
        else $error("Output off before the OFF delay elapsed.");
    AST_OFF_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !setupLevel && !stReg.latchEn[0] && !rawAlarm[0]
         && stReg.ch[0].st == aoc_pkg::AOC_OFFWAIT && stReg.ch[0].cnt > stReg.offDly[0])
        |=> !alarmState[0])
        else $error("Output still on after the OFF delay.");
    AST_OFF_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (stReg.ch[0].st == aoc_pkg::AOC_OFFWAIT) |-> alarmState[0])
        else $error("Output off during OFF delay.");
    AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && rawAlarm[0] != stReg.ch[0].rawLast) |=> (stReg.ch[0].cnt == 10'h000))
        else $error("Delay counter did not restart on a raw change.");
    AST_NODELAY: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !setupLevel && stReg.chType[2] == aoc_pkg::TYPE_NODELAY
         && stReg.ch[2].st == aoc_pkg::AOC_IDLE && rawAlarm[2]) |=> alarmState[2])
        else $error("Delay applied to a no-delay type.");
    AST_CNT_SAT: assert property (@(posedge clk) disable iff (!rst_n)
        (stReg.ch[0].cnt <= aoc_pkg::DELAY_MAX + 10'h001))
        else $error("Delay counter ran past its ceiling.");
    AST_LEVEL_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && setupLevel) |=> (stReg.ch[0].st == aoc_pkg::AOC_IDLE))
        else $error("Channel state not reset in setup level.");
    AST_AUX_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && setupLevel) |=> (auxOut == stReg.openInAlarm))
        else $error("Aux output not at rest level in setup level.");
    AST_TICK_GAP: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && stReg.tickCnt != 32'(TICK_CYCLES - 1)) |=> !stReg.tick)
        else $error("Tick outside its period.");

endmodule

/* core/aoc_pkg.sv */
// Purpose: Constants and carrier types for the four-channel alarm output conditioner.
// Assumes: One 200 MHz clock; raw alarm decisions arrive synchronous to it.
// Notes:   Register offsets are word indices on the plain register port.
package aoc_pkg;

    localparam int          CLK_HZ         = 200_000_000;
    localparam int          TICK_CYCLES    = CLK_HZ;
    localparam int          NUM_CH         = 4;
    localparam int          NUM_EVT        = 6;
    localparam logic [9:0]  DELAY_MAX      = 10'h3E7;
    localparam logic [9:0]  DELAY_RESET    = 10'h000;
    localparam logic [3:0]  TYPE_NONE      = 4'h0;
    localparam logic [3:0]  TYPE_LOOP      = 4'hC;
    localparam logic [3:0]  TYPE_NODELAY   = 4'hD;

    localparam logic [3:0]  REG_ON_DELAY0  = 4'h0;
    localparam logic [3:0]  REG_OFF_DELAY0 = 4'h4;
    localparam logic [3:0]  REG_TYPES      = 4'h8;
    localparam logic [3:0]  REG_CONFIG     = 4'h9;
    localparam logic [3:0]  REG_STATUS     = 4'hA;
    localparam logic [3:0]  REG_IRQ_STAT   = 4'hB;
    localparam logic [3:0]  REG_IRQ_MASK   = 4'hC;
    localparam logic [3:0]  REG_STATE      = 4'hD;

    localparam int          CFG_LATCH      = 0;
    localparam int          CFG_OPEN       = 4;
    localparam int          CFG_ASSIGN     = 8;
    localparam int          CFG_KEYLAT     = 12;
    localparam int          CFG_EVTLAT     = 16;

    typedef enum logic [1:0] {
        AOC_IDLE    = 2'b00,
        AOC_ONWAIT  = 2'b01,
        AOC_ACTIVE  = 2'b11,
        AOC_OFFWAIT = 2'b10
    } aoc_chst_t;

    typedef struct packed {
        aoc_chst_t  st;
        logic [9:0] cnt;
        logic       rawLast;
        logic       latched;
    } aoc_ch_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic       wr;
        logic       rd;
    } aoc_bus_t;

endpackage

/* verif/aoc_alarm_source.sv */
// Purpose: Far-side model of the alarm comparison logic feeding the conditioner.
// Assumes: The bench asks for raw alarm levels; the model launches them after a clock edge.
// Notes:   Registering the request keeps every raw change clear of the sampling edge.
`timescale 1ns/1ps
module aoc_alarm_source (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] rawReq,
    output logic      [3:0] rawAlarm
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rawAlarm <= 4'h0;
        end else begin
            rawAlarm <= rawReq;
        end
    end
endmodule

/* verif/tb.sv */
// Purpose: Self-checking bench for the alarm output conditioner.
// Assumes: A short tick of ten cycles stands in for one second.
// Notes:   Delay windows allow one tick of slack, since the tick phase is free-running.
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin failures++; $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
    localparam int TICKS = 10;
    logic        clk, rst_n, clkEn, regWr, regRd, functionKey, setupLevel, irq;
    logic [3:0]  regAddr, rawReq, rawAlarm, auxOut, alarmState;
    logic [31:0] regWdata, regRdata, d;
    logic [5:0]  eventIn;
    int          failures, nCompared, cycles, n;

    aoc_alarm_source src (.clk(clk), .rst_n(rst_n), .rawReq(rawReq), .rawAlarm(rawAlarm));
    aoc_alarm_conditioner #(.TICK_CYCLES(TICKS)) dut (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rawAlarm(rawAlarm),
        .functionKey(functionKey), .eventIn(eventIn), .setupLevel(setupLevel),
        .auxOut(auxOut), .alarmState(alarmState), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic setRaw(input logic [3:0] v);
        @(posedge clk);
        rawReq <= v;
        cyc(2);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        if (k < 0) functionKey <= 1'b1; else eventIn[k] <= 1'b1;
        @(posedge clk);
        functionKey <= 1'b0;
        eventIn <= 6'h00;
        cyc(2);
    endtask
    task automatic waitFor(input int bitIdx, input logic v);
        n = 0;
        while (alarmState[bitIdx] !== v && n < 100) begin
            cyc(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tReset;
        rd(aoc_pkg::REG_CONFIG);     `CHK(d, 32'h0000_0000)
        rd(aoc_pkg::REG_ON_DELAY0);  `CHK(d, 32'h0000_0000)
        rd(aoc_pkg::REG_OFF_DELAY0); `CHK(d, 32'h0000_0000)
        `CHK({alarmState, auxOut, irq}, 9'h000)
    endtask
    task automatic tZero;
        wr(aoc_pkg::REG_TYPES, 32'h0000_0D11);
        wr(aoc_pkg::REG_CONFIG, 32'h0000_0F20);
        wr(aoc_pkg::REG_ON_DELAY0 + 4'h2, 32'h0000_0003);
        setRaw(4'h5);
        `CHK(alarmState, 4'h5)
        `CHK(auxOut, 4'h7)
        setRaw(4'h0);
        `CHK(alarmState, 4'h0)
        `CHK(auxOut, 4'h2)
    endtask
    task automatic tDelay;
        wr(aoc_pkg::REG_ON_DELAY0, 32'h0000_0002);
        wr(aoc_pkg::REG_OFF_DELAY0, 32'h0000_0001);
        setRaw(4'h1);
        waitFor(0, 1'b1);
        `CHK(n > 2 * TICKS && n <= 3 * TICKS + 1, 1'b1)
        setRaw(4'h0);
        cyc(3);
        setRaw(4'h1);
        cyc(2 * TICKS);
        `CHK(alarmState[0], 1'b1)
        setRaw(4'h0);
        waitFor(0, 1'b0);
        `CHK(n > TICKS && n <= 2 * TICKS + 1, 1'b1)
        wr(aoc_pkg::REG_OFF_DELAY0, 32'h0000_03FF);
        rd(aoc_pkg::REG_OFF_DELAY0); `CHK(d, 32'h0000_03E7)
        wr(aoc_pkg::REG_OFF_DELAY0, 32'h0000_0000);
        wr(aoc_pkg::REG_ON_DELAY0, 32'h0000_0000);
    endtask
    task automatic tFreeze;
        @(posedge clk);
        clkEn <= 1'b0;
        setRaw(4'h1);
        cyc(3);
        `CHK(alarmState, 4'h0)
        @(posedge clk);
        clkEn <= 1'b1;
        cyc(2);
        `CHK(alarmState, 4'h1)
        setRaw(4'h0);
    endtask
    task automatic tLatch;
        // Channel 1 is a loop type, so its latch enable must be ignored.
        wr(aoc_pkg::REG_TYPES, 32'h0000_00C1);
        wr(aoc_pkg::REG_CONFIG, 32'h0020_1F13);
        setRaw(4'h3);
        setRaw(4'h0);
        `CHK(alarmState[1:0], 2'b01)
        `CHK(auxOut[0], 1'b0)
        @(posedge clk);
        setupLevel <= 1'b1;
        cyc(2);
        `CHK(alarmState[0], 1'b0)
        @(posedge clk);
        setupLevel <= 1'b0;
        cyc(2);
        `CHK(alarmState[0], 1'b1)
        pulse(-1);
        `CHK(alarmState[0], 1'b0)
        setRaw(4'h1);
        setRaw(4'h0);
        pulse(4);
        `CHK(alarmState[0], 1'b1)
        pulse(5);
        `CHK(alarmState[0], 1'b0)
    endtask
    task automatic tSetupAndIrq;
        rd(aoc_pkg::REG_IRQ_STAT);
        setRaw(4'h4);
        `CHK(irq, 1'b0)
        wr(aoc_pkg::REG_IRQ_MASK, 32'h0000_0004);
        cyc(2);
        `CHK(irq, 1'b1)
        rd(aoc_pkg::REG_IRQ_STAT); `CHK(d[3:0], 4'h4)
        cyc(2);
        `CHK(irq, 1'b0)
        @(posedge clk);
        setupLevel <= 1'b1;
        cyc(2);
        `CHK(alarmState, 4'h0)
        @(posedge clk);
        setupLevel <= 1'b0;
        setRaw(4'h0);
        rd(4'hE); `CHK(d, 32'h0000_0000)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Counts: %0d mismatches, %0d comparisons", failures, nCompared);
        if (failures == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        {rst_n, regWr, regRd, functionKey, setupLevel} = 5'h00;
        {regAddr, rawReq, eventIn, regWdata} = '0;
        clkEn = 1'b1;
        {failures, nCompared, cycles} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        tReset();
        tZero();
        tDelay();
        tFreeze();
        tLatch();
        tSetupAndIrq();
        tally_and_finish();
    end
endmodule
